/* pam_mapper.sv */
/*
 * Page address mapper top: translates processor addresses through a
 * writable page table in full 24-bit or banked 16-bit mode, loads the
 * table by index register or by redirected writes.
 * Assumes processor buses and strobes are synchronous to clock and that
 * io_wr and cpu_req are one-cycle strobes.
 */
// Functional notes
// - full mode: upper 12 page, lower 12 offset
// - page number indexes table, returns page, status
// - entry supplies physical page and exception status
// - entry write data comes from processor bus
// - banked index: 8 address lines plus bank
// - banked address: table page above 8 lines
// - index register selects entry for port loads
// - redirect bit steers writes into the table
// - banked mode uses only a 64K logical space
`default_nettype none

module pam_mapper
  import pam_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // processor memory cycle
  input wire logic [pam_pkg::VA_W-1:0] cpu_addr,
  input wire logic [pam_pkg::DATA_W-1:0] cpu_data,
  input wire logic cpu_req,
  input wire logic cpu_we,
  // processor i/o port
  input wire logic io_wr,
  input wire logic [1:0] io_port,
  // main memory side
  output logic mem_req,
  output logic mem_we,
  output logic [pam_pkg::VA_W-1:0] mem_addr,
  output logic [pam_pkg::STS_W-1:0] mem_status,
  // mode status
  output logic redirect_on,
  output logic banked_on
);

  import pam_pkg::*;

  // ---------------------------------------------------------------------
  // index decode
  // ---------------------------------------------------------------------
  // table index for either mode; bits above the 64K space are dropped in banked mode only
  function automatic logic [VPN_W-1:0] tbl_index(
    input logic [VA_W-1:0] addr,
    input logic banked,
    input logic [BANK_W-1:0] bank
  );
    logic [VPN_W-1:0] idx;
    idx = addr[VA_W-1:OFF_W];
    if (banked) begin
      idx = {bank, addr[LOG_W-1:BK_OFF_W]};
    end
    return idx;
  endfunction

  logic [CTRL_W-1:0] ctrl_q;
  logic [BANK_W-1:0] bank_q;
  logic [VPN_W-1:0] index_q;
  logic redir;
  logic banked;
  logic [VPN_W-1:0] tbl_idx;
  logic load_wr;
  logic redir_wr;
  logic tbl_we;
  logic [VPN_W-1:0] tbl_waddr;
  logic [ENT_W-1:0] tbl_wdata;
  logic [ENT_W-1:0] rd_data;

  assign redir = ctrl_q[CTRL_REDIR];
  assign banked = ctrl_q[CTRL_BANKED];
  assign tbl_idx = tbl_index(cpu_addr, banked, bank_q);

  // ---------------------------------------------------------------------
  // port registers
  // ---------------------------------------------------------------------
  // control and bank select come up cleared so redirect starts off
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ctrl_q <= CTRL_RST;
      bank_q <= BANK_RST;
    end else if (io_wr) begin
      if (io_port == PORT_CTRL) begin
        ctrl_q <= cpu_data[CTRL_W-1:0];
      end
      if (io_port == PORT_BANK) begin
        bank_q <= cpu_data[BANK_W-1:0];
      end
    end
  end

  // index register for port loads
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      index_q <= INDEX_RST;
    end else if (io_wr && io_port == PORT_INDEX) begin
      index_q <= cpu_data[VPN_W-1:0];
    end
  end

  // ---------------------------------------------------------------------
  // table write path
  // ---------------------------------------------------------------------
  // port load wins over a redirected write in the same cycle; the
  // redirected one is then lost, software should not overlap them
  assign load_wr = io_wr && io_port == PORT_LOAD;
  assign redir_wr = cpu_req && cpu_we && redir;
  assign tbl_we = load_wr || redir_wr;
  assign tbl_waddr = load_wr ? index_q : tbl_idx;
  assign tbl_wdata = cpu_data[ENT_W-1:0];

  pam_table #(
    .IDX_W(VPN_W),
    .WID(ENT_W)
  ) u_table (
    .clock(clock),
    .wr_en(tbl_we),
    .wr_idx(tbl_waddr),
    .wr_data(tbl_wdata),
    .rd_idx(tbl_idx),
    .rd_data(rd_data)
  );

  // ---------------------------------------------------------------------
  // translated cycle out to memory
  // ---------------------------------------------------------------------
  // one cycle of latency; all memory side outputs leave from flops
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      mem_req <= 1'b0;
      mem_we <= 1'b0;
    end else begin
      mem_req <= cpu_req && !(cpu_we && redir);
      mem_we <= cpu_req && cpu_we && !redir;
    end
  end

  // address and status follow every memory cycle; a redirected write
  // leaves them alone, its entry may not be loaded yet
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      mem_addr <= '0;
      mem_status <= '0;
    end else if (cpu_req && !redir_wr) begin
      if (banked) begin
        mem_addr <= {{(VA_W-BK_PA_W){1'b0}}, rd_data[PPN_W-1:0],
                     cpu_addr[BK_OFF_W-1:0]};
      end else begin
        mem_addr <= {rd_data[PPN_W-1:0], cpu_addr[OFF_W-1:0]};
      end
      mem_status <= rd_data[STS_LSB +: STS_W];
    end
  end

  // mode flags for the rest of the system
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      redirect_on <= 1'b0;
      banked_on <= 1'b0;
    end else begin
      redirect_on <= cpu_data[CTRL_REDIR] && io_wr && io_port == PORT_CTRL
                     || redir && !(io_wr && io_port == PORT_CTRL);
      banked_on <= cpu_data[CTRL_BANKED] && io_wr && io_port == PORT_CTRL
                   || banked && !(io_wr && io_port == PORT_CTRL);
    end
  end

  // ---------------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  property p_full_offset;
    cpu_req && !banked && !redir_wr |=>
      mem_addr[OFF_W-1:0] == $past(cpu_addr[OFF_W-1:0]);
  endproperty
  a_full_offset: assert property (p_full_offset)
    else $error("offset not passed through in full mode");

  property p_full_page;
    cpu_req && !banked && !redir_wr |=>
      mem_addr[VA_W-1:OFF_W] == $past(rd_data[PPN_W-1:0]);
  endproperty
  a_full_page: assert property (p_full_page)
    else $error("physical page not taken from entry");

  property p_status;
    cpu_req && !redir_wr |=>
      mem_status == $past(rd_data[STS_LSB +: STS_W]);
  endproperty
  a_status: assert property (p_status)
    else $error("status bits not taken from entry");

  property p_load_data;
    load_wr ##1 (cpu_req && !tbl_we && tbl_idx == $past(index_q)) |->
      rd_data == $past(cpu_data);
  endproperty
  a_load_data: assert property (p_load_data)
    else $error("loaded entry not from data bus");

  property p_bank_index;
    banked |-> tbl_idx[VPN_W-1:BK_HI_W] == bank_q &&
      tbl_idx[BK_HI_W-1:0] == cpu_addr[LOG_W-1:BK_OFF_W];
  endproperty
  a_bank_index: assert property (p_bank_index)
    else $error("banked index wrong");

  property p_bank_addr;
    cpu_req && banked && !redir_wr |=> mem_addr[VA_W-1:BK_PA_W] == '0 &&
      mem_addr[BK_OFF_W-1:0] == $past(cpu_addr[BK_OFF_W-1:0]) &&
      mem_addr[BK_PA_W-1:BK_OFF_W] == $past(rd_data[PPN_W-1:0]);
  endproperty
  a_bank_addr: assert property (p_bank_addr)
    else $error("banked physical address wrong");

  property p_index_load;
    load_wr |-> tbl_we && tbl_waddr == index_q;
  endproperty
  a_index_load: assert property (p_index_load)
    else $error("port load not at index register");

  property p_redirect;
    cpu_req && cpu_we && redir |=> !mem_req && !mem_we;
  endproperty
  a_redirect: assert property (p_redirect)
    else $error("redirected write reached memory");

  property p_logical_64k;
    banked |-> tbl_idx == tbl_index({8'h00, cpu_addr[LOG_W-1:0]}, 1'b1,
                                    bank_q);
  endproperty
  a_logical_64k: assert property (p_logical_64k)
    else $error("banked index uses lines above 64K");

  property p_reset_clear;
    $past(rst) |-> bank_q == BANK_RST && ctrl_q == CTRL_RST &&
      !redirect_on;
  endproperty
  a_reset_clear: assert property (disable iff (1'b0) p_reset_clear)
    else $error("bank or redirect not cleared by reset");

  property p_cov_redirect;
    redir_wr;
  endproperty
  c_cov_redirect: cover property (p_cov_redirect);

  property p_cov_banked;
    cpu_req && banked ##1 mem_req;
  endproperty
  c_cov_banked: cover property (p_cov_banked);

  property p_cov_load;
    load_wr ##[1:4] cpu_req;
  endproperty
  c_cov_load: cover property (p_cov_load);

endmodule // pam_mapper

`default_nettype wire

/* pam_mem_model.sv */
/*
 * Main memory stand-in for the page address mapper: counts memory writes
 * and keeps the last physical address that it was given.
 * Assumes mem_req is a one-cycle strobe on the clock and that no wait
 * states are needed, since the mapper has no ready input.
 */
`default_nettype none

module pam_mem_model
  import pam_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // memory cycle from the mapper
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [pam_pkg::VA_W-1:0] mem_addr,
  // observation
  output logic [7:0] wr_count,
  output logic [pam_pkg::VA_W-1:0] last_addr
);
  timeunit 1ns;
  timeprecision 100ps;

  // every request is accepted at once; a redirected write must not show
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      wr_count <= 8'h00;
      last_addr <= 24'h000000;
    end else if (mem_req) begin
      last_addr <= mem_addr;
      if (mem_we) begin
        wr_count <= wr_count + 8'h01;
      end
    end
  end
endmodule // pam_mem_model

`default_nettype wire

/* pam_pkg.sv */
/*
 * Shared constants for the page address mapper: address widths, page table
 * entry layout, processor port codes and reset values.
 * Assumes a single system clock and a processor that drives its buses
 * synchronously to that clock.
 */
`default_nettype none

package pam_pkg;

  // ---------------------------------------------------------------------
  // address layout
  // ---------------------------------------------------------------------
  localparam int VA_W = 24;       // full translation address width
  localparam int OFF_W = 12;      // untranslated page offset
  localparam int VPN_W = 12;      // virtual page number, table index
  localparam int LOG_W = 16;      // banked logical space, 64K bytes
  localparam int BK_HI_W = 8;     // processor lines feeding the index
  localparam int BK_OFF_W = 8;    // untranslated low lines in banked mode
  localparam int BK_PA_W = 20;    // banked physical address width
  localparam int BANK_W = 4;      // bank select register width

  // ---------------------------------------------------------------------
  // page table entry
  // ---------------------------------------------------------------------
  localparam int PPN_W = 12;      // physical page bits
  localparam int STS_W = 4;       // exception status bits
  localparam int ENT_W = 16;      // whole entry, low part is the page
  localparam int DATA_W = 16;     // processor data bus
  localparam int STS_LSB = 12;    // status field position in an entry

  // ---------------------------------------------------------------------
  // processor i/o ports and control bits
  // ---------------------------------------------------------------------
  localparam logic [1:0] PORT_INDEX = 2'h0;  // index register
  localparam logic [1:0] PORT_BANK = 2'h1;   // bank select register
  localparam logic [1:0] PORT_CTRL = 2'h2;   // control register
  localparam logic [1:0] PORT_LOAD = 2'h3;   // entry write at index reg
  localparam int CTRL_W = 2;
  localparam int CTRL_REDIR = 0;  // writes go to the table, not memory
  localparam int CTRL_BANKED = 1; // 16-bit banked mode

  // ---------------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------------
  localparam logic [BANK_W-1:0] BANK_RST = 4'h0;
  localparam logic [CTRL_W-1:0] CTRL_RST = 2'h0;
  localparam logic [VPN_W-1:0] INDEX_RST = 12'h000;

endpackage

`default_nettype wire

/* pam_table.sv */
/*
 * Page table storage: one entry per index, synchronous write, read that
 * follows the index within the same cycle.
 * Assumes the caller registers whatever it takes from the read port.
 */
`default_nettype none

module pam_table #(
  parameter int IDX_W = 12,
  parameter int WID = 16
) (
  // clock
  input wire logic clock,
  // write port
  input wire logic wr_en,
  input wire logic [IDX_W-1:0] wr_idx,
  input wire logic [WID-1:0] wr_data,
  // read port
  input wire logic [IDX_W-1:0] rd_idx,
  output logic [WID-1:0] rd_data
);

  // no reset: contents stay undefined until software loads them
  logic [WID-1:0] mem [0:(1<<IDX_W)-1];

  // entry write
  always_ff @(posedge clock) begin
    if (wr_en) begin
      mem[wr_idx] <= wr_data;
    end
  end

  // lookup
  assign rd_data = mem[rd_idx];

  // ---------------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------------
  // a written entry must read back one cycle later at the same index
  property p_write_read;
    @(posedge clock) wr_en ##1 rd_idx == $past(wr_idx) |->
      rd_data == $past(wr_data);
  endproperty
  a_write_read: assert property (p_write_read)
    else $error("table entry does not hold written value");

endmodule // pam_table

`default_nettype wire

/* test_pam_mapper.sv */
/*
 * Self-checking bench for the page address mapper: port loads, full and
 * banked translation, redirected table writes, reset state.
 * Assumes a one-cycle answer to every processor cycle and that i/o port
 * writes take effect at the edge that samples them.
 */
`default_nettype none

module test_pam_mapper;
  timeunit 1ns;
  timeprecision 100ps;
  import pam_pkg::*;

  // ---------------------------------------------------------------
  // signals and counters
  // ---------------------------------------------------------------
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic [VA_W-1:0] cpu_addr = 24'h000000;
  logic [DATA_W-1:0] cpu_data = 16'h0000;
  logic cpu_req = 1'b0;
  logic cpu_we = 1'b0;
  logic io_wr = 1'b0;
  logic [1:0] io_port = 2'h0;
  logic mem_req, mem_we, redirect_on, banked_on;
  logic [VA_W-1:0] mem_addr, last_addr;
  logic [STS_W-1:0] mem_status;
  logic [7:0] wr_count, wr_before;
  int miscompares = 0;
  int tests_run = 0;

  pam_mapper uut (.clock(clock), .rst(rst), .cpu_addr(cpu_addr),
    .cpu_data(cpu_data), .cpu_req(cpu_req), .cpu_we(cpu_we),
    .io_wr(io_wr), .io_port(io_port), .mem_req(mem_req), .mem_we(mem_we),
    .mem_addr(mem_addr), .mem_status(mem_status),
    .redirect_on(redirect_on), .banked_on(banked_on));

  pam_mem_model mem (.clock(clock), .rst(rst), .mem_req(mem_req),
    .mem_we(mem_we), .mem_addr(mem_addr), .wr_count(wr_count),
    .last_addr(last_addr));

  // 100 MHz clock
  initial begin
    forever #5 clock = ~clock;
  end

  // ---------------------------------------------------------------
  // drivers and compares
  // ---------------------------------------------------------------
  // strobes are left up so back-to-back calls never clear and set at once
  task automatic io(input logic [1:0] p, input logic [15:0] d);
    io_wr = 1'b1;
    cpu_req = 1'b0;
    io_port = p;
    cpu_data = d;
    @(posedge clock);
    #1;
  endtask

  task automatic cpu(input logic [23:0] a, input logic w,
                     input logic [15:0] d);
    cpu_req = 1'b1;
    io_wr = 1'b0;
    cpu_addr = a;
    cpu_we = w;
    cpu_data = d;
    @(posedge clock);
    #1;
  endtask

  task automatic idle();
    io_wr = 1'b0;
    cpu_req = 1'b0;
    @(posedge clock);
    #1;
  endtask

  task automatic chk_val(input logic [23:0] got, input logic [23:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: flag %b expected %b", $time, got, exp);
    end
  endtask

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_reset();
    chk_bit(mem_req, 1'b0);
    chk_bit(redirect_on, 1'b0);
    chk_bit(banked_on, 1'b0);
    $display("test reset done");
  endtask

  // two entries loaded by index register, then a read and a write back to back
  task automatic t_full();
    io(PORT_INDEX, 16'h0ABC);
    io(PORT_LOAD, 16'h5123);
    io(PORT_INDEX, 16'h0ABD);
    io(PORT_LOAD, 16'hA456);
    cpu(24'hABC7F1, 1'b0, 16'h0000);
    chk_val(mem_addr, 24'h1237F1);
    chk_val({20'h0, mem_status}, 24'h000005);
    chk_bit(mem_req, 1'b1);
    cpu(24'hABD00F, 1'b1, 16'h0000);
    chk_val(mem_addr, 24'h45600F);
    chk_val({20'h0, mem_status}, 24'h00000A);
    chk_bit(mem_we, 1'b1);
    idle();
    chk_bit(mem_req, 1'b0);
    chk_val(last_addr, 24'h45600F);
    $display("test full done");
  endtask

  // a write with redirect on lands in the table, never in memory
  task automatic t_redir();
    wr_before = wr_count;
    io(PORT_CTRL, 16'h0001);
    cpu(24'h3217AA, 1'b1, 16'h9876);
    chk_bit(mem_req, 1'b0);
    chk_bit(redirect_on, 1'b1);
    io(PORT_CTRL, 16'h0000);
    chk_val({16'h0, wr_count}, {16'h0, wr_before});
    cpu(24'h321000, 1'b0, 16'h0000);
    chk_val(mem_addr, 24'h876000);
    chk_val({20'h0, mem_status}, 24'h000009);
    idle();
    $display("test redirect done");
  endtask

  // bank 6 from the low data bits; upper address byte must not matter
  task automatic t_bank();
    io(PORT_CTRL, 16'h0002);
    io(PORT_BANK, 16'hFFF6);
    io(PORT_INDEX, 16'h06C3);
    io(PORT_LOAD, 16'h3ABC);
    cpu(24'hEEC355, 1'b0, 16'h0000);
    chk_val(mem_addr, 24'h0ABC55);
    chk_val({20'h0, mem_status}, 24'h000003);
    chk_bit(banked_on, 1'b1);
    idle();
    $display("test banked done");
  endtask

  // reset in mid-run drops both modes; table keeps its entries
  task automatic t_midreset();
    io(PORT_CTRL, 16'h0003);
    idle();
    chk_bit(redirect_on, 1'b1);
    rst = 1'b1;
    @(posedge clock);
    #1;
    chk_bit(redirect_on, 1'b0);
    chk_bit(banked_on, 1'b0);
    rst = 1'b0;
    cpu(24'hABC123, 1'b0, 16'h0000);
    chk_val(mem_addr, 24'h123123);
    chk_val({20'h0, mem_status}, 24'h000005);
    idle();
    $display("test mid-run reset done");
  endtask

  // ---------------------------------------------------------------
  // main sequence and watchdog
  // ---------------------------------------------------------------
  initial begin
    repeat (12) @(posedge clock);
    #1;
    rst = 1'b0;
    t_reset();
    t_full();
    t_redir();
    t_bank();
    t_midreset();
    end_of_test();
  end

  // a hang counts as a mismatch and ends the run
  initial begin
    #100000;
    miscompares++;
    end_of_test();
  end
endmodule // test_pam_mapper

`default_nettype wire
